// File: rtl/rpc_params.svh
// Constants for the repeater pin configuration block: strap indices,
// register map, field positions, reset values and loader timing.
// Assumes inclusion by bare name from rtl/ files and from the test bench.
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// Strap positions in the decoder array
`define RPC_NSTRAP 11
`define RPC_S_EQA0 0
`define RPC_S_EQA1 1
`define RPC_S_EQB0 2
`define RPC_S_EQB1 3
`define RPC_S_CHAN_A_DEEMPH_LEVEL 4
`define RPC_S_CHAN_B_DEEMPH_LEVEL 5
`define RPC_S_SWING 6
`define RPC_S_RECEIVER_DETECT_STRAP 7
`define RPC_S_RATE 8
`define RPC_S_SDTH 9
`define RPC_S_BUSEN 10
`define RPC_THERM_W 3

// Register byte addresses (word aligned) and decode width
`define RPC_ADDR_W 4
`define RPC_REG_CTRL 4'h0
`define RPC_REG_STATUS 4'h4
`define RPC_REG_EEDATA 4'h8

// Control register fields
`define RPC_CTRL_W 8
`define RPC_CTRL_RST 8'h00
`define RPC_CTRL_EQA_LSB 0
`define RPC_CTRL_EQB_LSB 2
`define RPC_CTRL_CHAN_A_DEEMPH_LEVEL_LSB 4
`define RPC_CTRL_CHAN_B_DEEMPH_LEVEL_LSB 6

// Status register fields
`define RPC_ST_DONE 0
`define RPC_ST_ERR 1
`define RPC_ST_MODE_LSB 2
`define RPC_ST_RATE_LSB 4
`define RPC_ST_LOWPWR 6
`define RPC_ST_TERM50 7

// EEPROM image: one byte per channel, eq in [1:0], de-emphasis in [3:2]
`define RPC_EE_BYTES 2
`define RPC_EE_EQ_LSB 0
`define RPC_EE_DEM_LSB 2
`define RPC_EE_DEV_RD 8'ha1
`define RPC_EE_DATA_RST 16'h0000

// Loader timing: SCL rate derived from the reference clock
`define RPC_CLK_KHZ 250000
`define RPC_SCL_KHZ 100
`define RPC_QTR_CYC ((`RPC_CLK_KHZ) / ((`RPC_SCL_KHZ) * 4))
`define RPC_QTR_W 10

`endif

// File: rtl/rpc_pkg.sv
// Types shared by the repeater pin configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rpc_pkg;
  typedef enum logic [1:0] {RPC_LVL_LOW, RPC_LVL_RGND, RPC_LVL_FLOAT, RPC_LVL_HIGH} rpc_lvl_t;
  typedef enum logic [1:0] {RPC_MODE_PIN, RPC_MODE_EEPROM, RPC_MODE_SLAVE} rpc_mode_t;
  typedef enum logic [1:0] {
    RPC_RATE_GEN12, RPC_RATE_AUTO, RPC_RATE_GEN3_NODEM, RPC_RATE_GEN3_DEM
  } rpc_rate_t;
  typedef enum logic [2:0] {
    RPC_LD_IDLE, RPC_LD_START, RPC_LD_TX, RPC_LD_TXACK, RPC_LD_RX, RPC_LD_RXACK, RPC_LD_STOP
  } rpc_ld_state_t;
endpackage
`default_nettype wire

// File: rtl/rpc_strap_if.sv
// Carries one strap's raw comparator thermometer and its resolved level.
// Assumes the pad comparators deliver a thermometer code.
`default_nettype none
interface rpc_strap_if;
  logic [2:0] therm;
  rpc_pkg::rpc_lvl_t code;
  modport dec (input therm, output code);
  modport user (output therm, input code);
endinterface
`default_nettype wire

// File: rtl/rpc_strap_decode.sv
// Resolves one multi-level strap into a held level code.
// Assumes a thermometer from three pad comparators, synchronous to clk.
`default_nettype none
`include "rpc_params.svh"
module rpc_strap_decode (
  input wire logic clk,
  input wire logic rst_n,
  rpc_strap_if.dec sp
);
  rpc_pkg::rpc_lvl_t code_r;
  rpc_pkg::rpc_lvl_t code_nxt;

  // Illegal (bubbled) codes keep the last level, so a slow edge cannot glitch a setting
  always_comb begin
    unique case (sp.therm)
      3'h0: code_nxt = rpc_pkg::RPC_LVL_LOW;
      3'h1: code_nxt = rpc_pkg::RPC_LVL_RGND;
      3'h3: code_nxt = rpc_pkg::RPC_LVL_FLOAT;
      3'h7: code_nxt = rpc_pkg::RPC_LVL_HIGH;
      default: code_nxt = code_r;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= rpc_pkg::RPC_LVL_LOW;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign sp.code = code_r;
endmodule
`default_nettype wire

// File: rtl/rpc_top.sv
// Pin configuration and mode selection for a one-lane repeater: strap
// decode, EEPROM loader and an AHB-Lite register slave.
// Assumes synchronous inputs on REF_CLK; open-drain pins resolved outside.
//
// Summary of operation
// - In EEPROM mode a high-to-low step on the load-start input begins the EEPROM fetch.
// - The load status output is high while loading or after a failure, low after a clean load.
// - In pin mode each channel's two-bit equalization comes from its two straps, ignored in EEPROM mode.
// - With the bus enable strap high, registers set each channel and the eq straps form the address.
// - De-emphasis follows each channel's strap only in pin mode; in bus modes they are SDA/SCL.
// - The presence input high puts the device in low power; low means normal operation.
// - Rate strap: low gen1/2, float auto, resistor to ground gen3 without, high gen3 with DEM.
// - The receiver-detect strap picks 50 ohm or high-impedance input termination.
// - Signal-detect threshold and output swing settings come from their own straps.
// - Bus enable strap: high bus slave, float EEPROM master, low pin control.
`default_nettype none
`include "rpc_params.svh"
module rpc_top #(
  parameter int EE_BYTES = `RPC_EE_BYTES
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [5:0] CHAN_A_EQUALIZER_LEVEL,
  input wire logic [5:0] CHAN_B_EQUALIZER_LEVEL,
  input wire logic [2:0] CHAN_A_DEEMPH_LEVEL,
  input wire logic [2:0] CHAN_B_DEEMPH_LEVEL,
  input wire logic [2:0] OUTPUT_SWING_SELECT,
  input wire logic [2:0] RECEIVER_DETECT_STRAP,
  input wire logic [2:0] RATE_STRAP,
  input wire logic [2:0] SIGNAL_DETECT_THRESHOLD,
  input wire logic [2:0] MGMT_BUS_ENABLE_STRAP,
  input wire logic PRESENCE_LOW_POWER,
  input wire logic EEPROM_LOAD_START_N,
  input wire logic SDA_I,
  input wire logic SCL_I,
  output logic SDA_O,
  output logic SDA_OEN,
  output logic SCL_O,
  output logic SCL_OEN,
  output logic LOAD_STATUS,
  output logic [1:0] CFG_MODE,
  output logic [1:0] CFG_EQ_A,
  output logic [1:0] CFG_EQ_B,
  output logic [1:0] CFG_DEEMPH_A,
  output logic [1:0] CFG_DEEMPH_B,
  output logic [1:0] CFG_RATE,
  output logic CFG_RX_TERM_50,
  output logic [1:0] CFG_SD_THRESH,
  output logic [1:0] CFG_SWING,
  output logic LOW_POWER,
  output logic [3:0] MGMT_SLAVE_ADDR
);
  localparam int DATA_W = 8 * EE_BYTES;
  localparam logic [`RPC_QTR_W-1:0] QTR = `RPC_QTR_W'(`RPC_QTR_CYC - 1);

  function automatic logic is_high(input rpc_pkg::rpc_lvl_t l);
    is_high = (l == rpc_pkg::RPC_LVL_HIGH);
  endfunction

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Strap decoders
  logic [`RPC_NSTRAP*`RPC_THERM_W-1:0] therm_all;
  rpc_pkg::rpc_lvl_t lvl [`RPC_NSTRAP];
  assign therm_all = {MGMT_BUS_ENABLE_STRAP, SIGNAL_DETECT_THRESHOLD, RATE_STRAP,
                      RECEIVER_DETECT_STRAP, OUTPUT_SWING_SELECT, CHAN_B_DEEMPH_LEVEL,
                      CHAN_A_DEEMPH_LEVEL, CHAN_B_EQUALIZER_LEVEL, CHAN_A_EQUALIZER_LEVEL};

  rpc_strap_if sif [`RPC_NSTRAP] ();
  genvar g;
  generate
    for (g = 0; g < `RPC_NSTRAP; g++) begin : g_strap
      assign sif[g].therm = therm_all[g*`RPC_THERM_W +: `RPC_THERM_W];
      assign lvl[g] = sif[g].code;
      rpc_strap_decode u_dec (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .sp(sif[g])
      );
    end
  endgenerate

  rpc_pkg::rpc_mode_t mode;
  always_comb begin
    unique case (lvl[`RPC_S_BUSEN])
      rpc_pkg::RPC_LVL_HIGH: mode = rpc_pkg::RPC_MODE_SLAVE;
      rpc_pkg::RPC_LVL_FLOAT: mode = rpc_pkg::RPC_MODE_EEPROM;
      default: mode = rpc_pkg::RPC_MODE_PIN;
    endcase
  end

  // EEPROM loader state
  rpc_pkg::rpc_ld_state_t st_r, st_nxt;
  logic [1:0] q_r, q_nxt;
  logic [`RPC_QTR_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [$clog2(EE_BYTES+1)-1:0] byte_r, byte_nxt;
  logic [DATA_W-1:0] ee_data_r, ee_data_nxt;
  logic done_r, done_nxt;
  logic err_r, err_nxt;
  logic nack_r, nack_nxt;
  logic scl_low_r, scl_low_nxt;
  logic sda_low_r, sda_low_nxt;
  logic start_prev_r;
  logic last_byte;

  assign last_byte = (byte_r == ($bits(byte_r))'(EE_BYTES - 1));

  always_comb begin
    st_nxt = st_r;
    q_nxt = q_r;
    cnt_nxt = cnt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    byte_nxt = byte_r;
    ee_data_nxt = ee_data_r;
    done_nxt = done_r;
    err_nxt = err_r;
    nack_nxt = nack_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    if (st_r == rpc_pkg::RPC_LD_IDLE) begin
      // Falls outside EEPROM mode are ignored; slave mode expects the pin held low
      if (mode == rpc_pkg::RPC_MODE_EEPROM && start_prev_r && !EEPROM_LOAD_START_N) begin
        st_nxt = rpc_pkg::RPC_LD_START;
        q_nxt = 2'h0;
        cnt_nxt = QTR;
        bit_nxt = 3'h0;
        byte_nxt = '0;
        sh_nxt = `RPC_EE_DEV_RD;
        done_nxt = 1'b1;
        err_nxt = 1'b0;
      end
    end else if (mode != rpc_pkg::RPC_MODE_EEPROM) begin
      // Strap moved away mid-load: abandon and free the bus, status stays high
      st_nxt = rpc_pkg::RPC_LD_IDLE;
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      err_nxt = 1'b1;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else if (q_r == 2'h1 && !SCL_I) begin
      // A slave stretching SCL holds the high phase open
      cnt_nxt = '0;
    end else begin
      cnt_nxt = QTR;
      q_nxt = q_r + 2'h1;
      unique case (st_r)
        rpc_pkg::RPC_LD_START: begin
          if (q_r == 2'h1) sda_low_nxt = 1'b1;
          if (q_r == 2'h2) scl_low_nxt = 1'b1;
          if (q_r == 2'h3) begin
            sda_low_nxt = ~sh_r[7];
            st_nxt = rpc_pkg::RPC_LD_TX;
          end
        end
        rpc_pkg::RPC_LD_TX: begin
          if (q_r == 2'h0) scl_low_nxt = 1'b0;
          if (q_r == 2'h2) scl_low_nxt = 1'b1;
          if (q_r == 2'h3) begin
            if (bit_r == 3'h7) begin
              sda_low_nxt = 1'b0;
              st_nxt = rpc_pkg::RPC_LD_TXACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              sda_low_nxt = ~sh_r[6];
              bit_nxt = bit_r + 3'h1;
            end
          end
        end
        rpc_pkg::RPC_LD_TXACK: begin
          if (q_r == 2'h0) scl_low_nxt = 1'b0;
          if (q_r == 2'h1) nack_nxt = SDA_I;
          if (q_r == 2'h2) scl_low_nxt = 1'b1;
          if (q_r == 2'h3) begin
            bit_nxt = 3'h0;
            if (nack_r) begin
              err_nxt = 1'b1;
              sda_low_nxt = 1'b1;
              st_nxt = rpc_pkg::RPC_LD_STOP;
            end else begin
              st_nxt = rpc_pkg::RPC_LD_RX;
            end
          end
        end
        rpc_pkg::RPC_LD_RX: begin
          if (q_r == 2'h0) scl_low_nxt = 1'b0;
          if (q_r == 2'h1) sh_nxt = {sh_r[6:0], SDA_I};
          if (q_r == 2'h2) scl_low_nxt = 1'b1;
          if (q_r == 2'h3) begin
            if (bit_r == 3'h7) begin
              ee_data_nxt[8*byte_r +: 8] = sh_r;
              sda_low_nxt = ~last_byte;
              st_nxt = rpc_pkg::RPC_LD_RXACK;
            end else begin
              bit_nxt = bit_r + 3'h1;
            end
          end
        end
        rpc_pkg::RPC_LD_RXACK: begin
          if (q_r == 2'h0) scl_low_nxt = 1'b0;
          if (q_r == 2'h2) scl_low_nxt = 1'b1;
          if (q_r == 2'h3) begin
            bit_nxt = 3'h0;
            if (last_byte) begin
              sda_low_nxt = 1'b1;
              st_nxt = rpc_pkg::RPC_LD_STOP;
            end else begin
              sda_low_nxt = 1'b0;
              byte_nxt = byte_r + 1'b1;
              st_nxt = rpc_pkg::RPC_LD_RX;
            end
          end
        end
        rpc_pkg::RPC_LD_STOP: begin
          if (q_r == 2'h0) scl_low_nxt = 1'b0;
          if (q_r == 2'h1) sda_low_nxt = 1'b0;
          if (q_r == 2'h3) begin
            done_nxt = err_r;
            st_nxt = rpc_pkg::RPC_LD_IDLE;
          end
        end
        default: st_nxt = rpc_pkg::RPC_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= rpc_pkg::RPC_LD_IDLE;
      q_r <= 2'h0;
      cnt_r <= '0;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      byte_r <= '0;
      ee_data_r <= DATA_W'(`RPC_EE_DATA_RST);
      done_r <= 1'b1;
      err_r <= 1'b0;
      nack_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      start_prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      byte_r <= byte_nxt;
      ee_data_r <= ee_data_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      nack_r <= nack_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
      start_prev_r <= EEPROM_LOAD_START_N;
    end
  end

  // AHB-Lite slave: zero wait states, read data registered in the address phase
  logic addr_ok;
  logic wr_pend_r, wr_pend_nxt;
  logic [`RPC_ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [`RPC_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [31:0] rdata_nxt;
  logic [7:0] status;

  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign status = {CFG_RX_TERM_50, LOW_POWER, CFG_RATE, CFG_MODE, err_r, done_r};

  always_comb begin
    wr_pend_nxt = addr_ok && HWRITE;
    wr_addr_nxt = HADDR[`RPC_ADDR_W-1:0];
    ctrl_nxt = ctrl_r;
    if (wr_pend_r && wr_addr_r == `RPC_REG_CTRL) begin
      ctrl_nxt = HWDATA[`RPC_CTRL_W-1:0];
    end
    rdata_nxt = HRDATA;
    if (addr_ok && !HWRITE) begin
      unique case (HADDR[`RPC_ADDR_W-1:0])
        `RPC_REG_CTRL: rdata_nxt = 32'(ctrl_nxt); // Forwards a write still in its data phase
        `RPC_REG_STATUS: rdata_nxt = 32'(status);
        `RPC_REG_EEDATA: rdata_nxt = 32'(ee_data_r);
        default: rdata_nxt = 32'h0000_0000;
      endcase
      if (HADDR[31:`RPC_ADDR_W] != '0) rdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      ctrl_r <= `RPC_CTRL_RST;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt && (HADDR[31:`RPC_ADDR_W] == '0);
      wr_addr_r <= wr_addr_nxt;
      ctrl_r <= ctrl_nxt;
      HRDATA <= rdata_nxt;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Configuration outputs
  logic [1:0] eq_a_nxt, eq_b_nxt, dem_a_nxt, dem_b_nxt, rate_nxt;
  logic [3:0] addr_nxt;

  always_comb begin
    unique case (mode)
      rpc_pkg::RPC_MODE_PIN: begin
        eq_a_nxt = {is_high(lvl[`RPC_S_EQA1]), is_high(lvl[`RPC_S_EQA0])};
        eq_b_nxt = {is_high(lvl[`RPC_S_EQB1]), is_high(lvl[`RPC_S_EQB0])};
        dem_a_nxt = lvl[`RPC_S_CHAN_A_DEEMPH_LEVEL];
        dem_b_nxt = lvl[`RPC_S_CHAN_B_DEEMPH_LEVEL];
        addr_nxt = 4'h0;
      end
      rpc_pkg::RPC_MODE_SLAVE: begin
        eq_a_nxt = ctrl_r[`RPC_CTRL_EQA_LSB +: 2];
        eq_b_nxt = ctrl_r[`RPC_CTRL_EQB_LSB +: 2];
        dem_a_nxt = ctrl_r[`RPC_CTRL_CHAN_A_DEEMPH_LEVEL_LSB +: 2];
        dem_b_nxt = ctrl_r[`RPC_CTRL_CHAN_B_DEEMPH_LEVEL_LSB +: 2];
        addr_nxt = {is_high(lvl[`RPC_S_EQB0]), is_high(lvl[`RPC_S_EQB1]),
                    is_high(lvl[`RPC_S_EQA1]), is_high(lvl[`RPC_S_EQA0])};
      end
      default: begin
        eq_a_nxt = ee_data_r[`RPC_EE_EQ_LSB +: 2];
        eq_b_nxt = ee_data_r[8 + `RPC_EE_EQ_LSB +: 2];
        dem_a_nxt = ee_data_r[`RPC_EE_DEM_LSB +: 2];
        dem_b_nxt = ee_data_r[8 + `RPC_EE_DEM_LSB +: 2];
        addr_nxt = 4'h0;
      end
    endcase
    unique case (lvl[`RPC_S_RATE])
      rpc_pkg::RPC_LVL_LOW: rate_nxt = rpc_pkg::RPC_RATE_GEN12;
      rpc_pkg::RPC_LVL_FLOAT: rate_nxt = rpc_pkg::RPC_RATE_AUTO;
      rpc_pkg::RPC_LVL_RGND: rate_nxt = rpc_pkg::RPC_RATE_GEN3_NODEM;
      default: rate_nxt = rpc_pkg::RPC_RATE_GEN3_DEM;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CFG_MODE <= 2'h0;
      CFG_EQ_A <= 2'h0;
      CFG_EQ_B <= 2'h0;
      CFG_DEEMPH_A <= 2'h0;
      CFG_DEEMPH_B <= 2'h0;
      CFG_RATE <= 2'h0;
      CFG_RX_TERM_50 <= 1'b0;
      CFG_SD_THRESH <= 2'h0;
      CFG_SWING <= 2'h0;
      LOW_POWER <= 1'b0;
      MGMT_SLAVE_ADDR <= 4'h0;
      LOAD_STATUS <= 1'b1;
      SCL_O <= 1'b0;
      SCL_OEN <= 1'b1;
      SDA_O <= 1'b0;
      SDA_OEN <= 1'b1;
    end else begin
      CFG_MODE <= mode;
      CFG_EQ_A <= eq_a_nxt;
      CFG_EQ_B <= eq_b_nxt;
      CFG_DEEMPH_A <= dem_a_nxt;
      CFG_DEEMPH_B <= dem_b_nxt;
      CFG_RATE <= rate_nxt;
      // Float or high gives 50 ohm; low or resistor leaves the high-impedance load
      CFG_RX_TERM_50 <= lvl[`RPC_S_RECEIVER_DETECT_STRAP] >= rpc_pkg::RPC_LVL_FLOAT;
      CFG_SD_THRESH <= lvl[`RPC_S_SDTH];
      CFG_SWING <= lvl[`RPC_S_SWING];
      LOW_POWER <= PRESENCE_LOW_POWER;
      MGMT_SLAVE_ADDR <= addr_nxt;
      LOAD_STATUS <= done_nxt;
      SCL_O <= 1'b0;
      SCL_OEN <= ~scl_low_nxt;
      SDA_O <= 1'b0;
      SDA_OEN <= ~sda_low_nxt;
    end
  end
endmodule
`default_nettype wire

// File: tb/rpc_top_assertions.sv
// Concurrent checks on the pin configuration top: strap decode, modes and loader status.
// Assumes it is bound to rpc_top and sees only that module's ports.
`default_nettype none
module rpc_chk (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [5:0] CHAN_A_EQUALIZER_LEVEL,
  input wire logic [5:0] CHAN_B_EQUALIZER_LEVEL,
  input wire logic [2:0] OUTPUT_SWING_SELECT,
  input wire logic [2:0] RECEIVER_DETECT_STRAP,
  input wire logic [2:0] RATE_STRAP,
  input wire logic [2:0] SIGNAL_DETECT_THRESHOLD,
  input wire logic [2:0] MGMT_BUS_ENABLE_STRAP,
  input wire logic PRESENCE_LOW_POWER,
  input wire logic EEPROM_LOAD_START_N,
  input wire logic SDA_OEN,
  input wire logic SCL_OEN,
  input wire logic LOAD_STATUS,
  input wire logic [1:0] CFG_MODE,
  input wire logic [1:0] CFG_EQ_A,
  input wire logic [1:0] CFG_RATE,
  input wire logic CFG_RX_TERM_50,
  input wire logic [1:0] CFG_SD_THRESH,
  input wire logic [1:0] CFG_SWING,
  input wire logic LOW_POWER,
  input wire logic [3:0] MGMT_SLAVE_ADDR
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r, cnt_nxt;
  logic ok;
  logic [3:0] adr_w;
  function automatic logic leg(logic [2:0] t);
    return t == 3'h0 || t == 3'h1 || t == 3'h3 || t == 3'h7;
  endfunction
  function automatic logic [1:0] lvl(logic [2:0] t);
    return {t[1], t[2] | (t[0] & ~t[1])};
  endfunction
  function automatic logic [1:0] rt(logic [2:0] t);
    return {t[2] | (t[0] & ~t[1]), t[1]};
  endfunction
  // Strap effects show two edges late, so checking waits out the reset synchroniser
  always_comb cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) cnt_r <= 3'h0;
    else cnt_r <= cnt_nxt;
  end
  assign ok = cnt_r == 3'h7;
  assign adr_w = {CHAN_B_EQUALIZER_LEVEL[2:0] == 3'h7, CHAN_B_EQUALIZER_LEVEL[5:3] == 3'h7,
                  CHAN_A_EQUALIZER_LEVEL[5:3] == 3'h7, CHAN_A_EQUALIZER_LEVEL[2:0] == 3'h7};
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ok);
  property p_rate;
    CFG_RATE == (leg($past(RATE_STRAP, 2)) ? rt($past(RATE_STRAP, 2)) : $past(CFG_RATE));
  endproperty
  property p_swing;
    leg($past(OUTPUT_SWING_SELECT, 2)) |-> CFG_SWING == lvl($past(OUTPUT_SWING_SELECT, 2));
  endproperty
  property p_sdth;
    leg($past(SIGNAL_DETECT_THRESHOLD, 2))
      |-> CFG_SD_THRESH == lvl($past(SIGNAL_DETECT_THRESHOLD, 2));
  endproperty
  property p_term;
    leg($past(RECEIVER_DETECT_STRAP, 2)) |-> CFG_RX_TERM_50 == $past(RECEIVER_DETECT_STRAP[1], 2);
  endproperty
  property p_mode;
    leg($past(MGMT_BUS_ENABLE_STRAP, 2)) |-> CFG_MODE ==
      {$past(MGMT_BUS_ENABLE_STRAP[2], 2), $past(MGMT_BUS_ENABLE_STRAP == 3'h3, 2)};
  endproperty
  property p_lowpwr;
    $stable(PRESENCE_LOW_POWER) |-> LOW_POWER == PRESENCE_LOW_POWER;
  endproperty
  property p_eq;
    $past(MGMT_BUS_ENABLE_STRAP, 2) == 3'h0 && $past(MGMT_BUS_ENABLE_STRAP, 3) == 3'h0
      |-> CFG_EQ_A == $past(adr_w[1:0], 2);
  endproperty
  property p_addr;
    $past(MGMT_BUS_ENABLE_STRAP, 2) == 3'h7 && $past(MGMT_BUS_ENABLE_STRAP, 3) == 3'h7
      |-> MGMT_SLAVE_ADDR == $past(adr_w, 2);
  endproperty
  property p_ld;
    $fell(EEPROM_LOAD_START_N) && CFG_MODE == 2'h1 |=> LOAD_STATUS [*8];
  endproperty
  property p_busy;
    !SCL_OEN |-> LOAD_STATUS;
  endproperty
  property p_done;
    $fell(LOAD_STATUS) |-> SDA_OEN && SCL_OEN && CFG_MODE == 2'h1;
  endproperty
  a_rate: assert property (p_rate) else $error("rate setting wrong");
  a_swing: assert property (p_swing) else $error("swing setting wrong");
  a_sdth: assert property (p_sdth) else $error("threshold setting wrong");
  a_term: assert property (p_term) else $error("termination wrong");
  a_mode: assert property (p_mode) else $error("mode wrong");
  a_lowpwr: assert property (p_lowpwr) else $error("low power wrong");
  a_eq: assert property (p_eq) else $error("pin eq wrong");
  a_addr: assert property (p_addr) else $error("slave address wrong");
  a_ld: assert property (p_ld) else $error("load start not reported");
  a_busy: assert property (p_busy) else $error("status low while loading");
  a_done: assert property (p_done) else $error("status low with bus held");
  c_start: cover property ($fell(EEPROM_LOAD_START_N) && CFG_MODE == 2'h1);
  c_done: cover property ($fell(LOAD_STATUS));
  c_slave: cover property (CFG_MODE == 2'h2);
endmodule
bind rpc_top rpc_chk u_chk (.*);
`default_nettype wire

// File: tb/rpc_ee_model.sv
// Behavioural configuration EEPROM on the loader's two-wire bus.
// Assumes resolved open-drain levels with pull-ups; answers only device read byte 8'ha1.
`default_nettype none
module rpc_ee_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [15:0] image,
  output logic sda_oen
);
  timeunit 1ns;
  timeprecision 1ps;
  int k = -1;
  int m;
  logic [7:0] sh;
  initial sda_oen = 1'b1;
  // Start and stop are only recognised while the clock line is high
  always @(negedge sda) if (scl) k = 0;
  always @(posedge sda) if (scl) k = -1;
  always @(posedge scl) begin
    if (k >= 0) k = k + 1;
    if (k >= 1 && k <= 8) sh = {sh[6:0], sda};
  end
  // Data change only while the clock is low; a foreign device byte is refused
  always @(negedge scl) begin
    m = k - 9;
    if (k == 8) sda_oen <= sh != 8'ha1;
    else if (m >= 0 && m < 18 && m % 9 != 8) sda_oen <= image[8 * (m / 9) + 7 - m % 9];
    else sda_oen <= 1'b1;
  end
endmodule
`default_nettype wire

// File: tb/repeater_pin_config_select_test.sv
// Self-checking bench for the repeater pin configuration top.
// Assumes rpc_top, the bound checker and the EEPROM model are compiled first.
`default_nettype none
`include "rpc_params.svh"
module repeater_pin_config_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic NRST, HSEL, HWRITE, HREADYOUT, HRESP, PRESENCE_LOW_POWER, EEPROM_LOAD_START_N;
  logic SDA_O, SDA_OEN, SCL_O, SCL_OEN, LOAD_STATUS, CFG_RX_TERM_50, LOW_POWER, ee_oen;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, CFG_MODE, CFG_EQ_A, CFG_EQ_B, CFG_DEEMPH_A, CFG_DEEMPH_B, CFG_RATE;
  logic [1:0] CFG_SD_THRESH, CFG_SWING;
  logic [2:0] HSIZE, CHAN_A_DEEMPH_LEVEL, CHAN_B_DEEMPH_LEVEL, OUTPUT_SWING_SELECT;
  logic [2:0] RECEIVER_DETECT_STRAP, RATE_STRAP, SIGNAL_DETECT_THRESHOLD, MGMT_BUS_ENABLE_STRAP;
  logic [5:0] CHAN_A_EQUALIZER_LEVEL, CHAN_B_EQUALIZER_LEVEL;
  logic [3:0] MGMT_SLAVE_ADDR;
  logic [15:0] img;
  wire logic HREADY, SDA_I, SCL_I;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam logic [2:0] TH [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  assign HREADY = HREADYOUT;
  assign SCL_I = SCL_OEN;
  assign SDA_I = SDA_OEN & ee_oen;
  rpc_top uut (.*);
  rpc_ee_model u_ee (.scl(SCL_I), .sda(SDA_I), .image(img), .sda_oen(ee_oen));
  always #2 REF_CLK = ~REF_CLK;
  function automatic logic [1:0] rate_of(int l);
    return l == 1 ? 2'h2 : l == 2 ? 2'h1 : 2'(l);
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // One single word transfer; the wait is bounded so a dead slave is reported
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADY !== 1'b1 && ++n < 50);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge REF_CLK); while (HREADY !== 1'b1 && ++n < 50);
    rd = HRDATA;
    if (n >= 50) n_mismatch++;
  endtask
  initial begin
    cyc(100000);
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic [7:0] c;
    int l;
    NRST = 1'b0;
    HSEL = 1'b1;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    {CHAN_A_DEEMPH_LEVEL, CHAN_B_DEEMPH_LEVEL, OUTPUT_SWING_SELECT} = 9'h0;
    {RECEIVER_DETECT_STRAP, RATE_STRAP, SIGNAL_DETECT_THRESHOLD} = 9'h0;
    MGMT_BUS_ENABLE_STRAP = 3'h0;
    {CHAN_A_EQUALIZER_LEVEL, CHAN_B_EQUALIZER_LEVEL} = 12'h0;
    PRESENCE_LOW_POWER = 1'b0;
    EEPROM_LOAD_START_N = 1'b1;
    img = 16'h0;
    l = $urandom(32'h2895);
    cyc(6);
    chk("reset_status", 1, LOAD_STATUS);
    NRST <= 1'b1;
    cyc(4);
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      RATE_STRAP <= TH[i % 4];
      OUTPUT_SWING_SELECT <= TH[r[1:0]];
      SIGNAL_DETECT_THRESHOLD <= TH[r[3:2]];
      RECEIVER_DETECT_STRAP <= TH[r[5:4]];
      CHAN_A_EQUALIZER_LEVEL <= {TH[r[7:6]], TH[r[9:8]]};
      CHAN_B_EQUALIZER_LEVEL <= {TH[r[11:10]], TH[r[13:12]]};
      CHAN_A_DEEMPH_LEVEL <= TH[r[15:14]];
      CHAN_B_DEEMPH_LEVEL <= TH[r[17:16]];
      PRESENCE_LOW_POWER <= r[18];
      cyc(3);
      chk("rate", rate_of(i % 4), CFG_RATE);
      chk("swing", r[1:0], CFG_SWING);
      chk("sd_thresh", r[3:2], CFG_SD_THRESH);
      chk("term50", r[5], CFG_RX_TERM_50);
      chk("eq_a", {&r[7:6], &r[9:8]}, CFG_EQ_A);
      chk("eq_b", {&r[11:10], &r[13:12]}, CFG_EQ_B);
      chk("deemph_a", r[15:14], CFG_DEEMPH_A);
      chk("deemph_b", r[17:16], CFG_DEEMPH_B);
      chk("low_power", r[18], LOW_POWER);
      chk("pin_addr", 0, MGMT_SLAVE_ADDR);
      chk("pin_mode", 0, CFG_MODE);
    end
    RATE_STRAP <= 3'h2;
    cyc(3);
    chk("rate_hold", rate_of(3), CFG_RATE);
    r = $urandom;
    c = r[15:8];
    EEPROM_LOAD_START_N <= 1'b0;
    MGMT_BUS_ENABLE_STRAP <= TH[3];
    CHAN_A_EQUALIZER_LEVEL <= {{3{r[1]}}, {3{r[0]}}};
    CHAN_B_EQUALIZER_LEVEL <= {{3{r[2]}}, {3{r[3]}}};
    CHAN_A_DEEMPH_LEVEL <= TH[~c[5:4]];
    cyc(3);
    chk("slave_mode", 2, CFG_MODE);
    chk("slave_addr", r[3:0], MGMT_SLAVE_ADDR);
    ahb(1'b1, `RPC_REG_CTRL, {24'h0, c});
    ahb(1'b0, `RPC_REG_CTRL, 32'h0);
    chk("ctrl", c, rd);
    cyc(2);
    chk("reg_eq_a", c[1:0], CFG_EQ_A);
    chk("reg_eq_b", c[3:2], CFG_EQ_B);
    chk("reg_dem_a", c[5:4], CFG_DEEMPH_A);
    chk("reg_dem_b", c[7:6], CFG_DEEMPH_B);
    ahb(1'b0, 32'hc, 32'h0);
    chk("unmapped", 0, rd);
    ahb(1'b0, `RPC_REG_STATUS, 32'h0);
    chk("st_mode", 2, rd[`RPC_ST_MODE_LSB +: 2]);
    for (int k = 0; k < 2; k++) begin
      MGMT_BUS_ENABLE_STRAP <= TH[2];
      img <= 16'($urandom);
      EEPROM_LOAD_START_N <= 1'b1;
      cyc(4);
      chk("ee_mode", 1, CFG_MODE);
      EEPROM_LOAD_START_N <= 1'b0;
      cyc(k == 0 ? 3000 : 1);
      // Pull the strap to pin mode while the device byte is still going out
      if (k == 0) begin
        MGMT_BUS_ENABLE_STRAP <= TH[0];
        cyc(4);
        chk("abort_scl", 1, SCL_OEN);
        ahb(1'b0, `RPC_REG_STATUS, 32'h0);
        chk("abort_flags", 3, rd[`RPC_ST_DONE +: 2]);
      end
    end
    // First pass above was cut short by leaving the mode; this one must finish
    for (l = 0; l < 80000 && LOAD_STATUS !== 1'b0; l++) @(posedge REF_CLK);
    chk("load_done", 0, LOAD_STATUS);
    cyc(3);
    chk("ee_eq_a", img[1:0], CFG_EQ_A);
    chk("ee_dem_a", img[3:2], CFG_DEEMPH_A);
    chk("ee_eq_b", img[9:8], CFG_EQ_B);
    chk("ee_dem_b", img[11:10], CFG_DEEMPH_B);
    ahb(1'b0, `RPC_REG_EEDATA, 32'h0);
    chk("eedata", img, rd);
    chk("pins_low", 0, {HRESP, SDA_O, SCL_O});
    conclude();
  end
endmodule
`default_nettype wire
